// ==== logic/osc_ctl_pkg.sv ====
// Package of offsets, field positions, reset values and carrier structs for the oscillator control block.
// What this block does
// - Low-power entry clears PLL and crystal enables.
// - Read-only stable flags for three PLLs.
// - Read-only crystal stable flag from hardware.
// - Main PLL enable clear ignored while system clock.
// - Crystal enable clear ignored while in use.
// - Monitored crystal failure forces RC system clock.
// - Forced RC holds until reset or flag clear.
// - Monitor enabled keeps RC oscillator running.
// - Bypass writable only while crystal disabled.
// - Bypass passes external clock as crystal output.
// - Calibration byte loaded at power-on, read-only.
// - Trim equals adjust plus calibration.
// - Reset value has bits 0,1,7 set.
// - Hardware sets RC enable; clear refused when used.
// - Read-only RC oscillator stable flag.
// - Crystal failure sets clock failure flag, NMI.
// - Crystal failure disables crystal and, when fed from it, the main PLL.
package osc_ctl_pkg;

  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;

  localparam int BIT_RC_ON = 0;
  localparam int BIT_RC_STABLE = 1;
  localparam int ADJ_LSB = 3;
  localparam int CAL_LSB = 8;
  localparam int BIT_CRYSTAL_ON = 16;
  localparam int BIT_CRYSTAL_STABLE = 17;
  localparam int BIT_BYPASS = 18;
  localparam int BIT_MONITOR_ON = 19;
  localparam int BIT_MAIN_PLL_ON = 24;
  localparam int BIT_MAIN_PLL_STABLE = 25;
  localparam int BIT_SECOND_PLL_ON = 26;
  localparam int BIT_SECOND_PLL_STABLE = 27;
  localparam int BIT_THIRD_PLL_ON = 28;
  localparam int BIT_THIRD_PLL_STABLE = 29;

  localparam int IRQ_FAIL = 0;
  localparam int IRQ_RC_READY = 1;
  localparam int IRQ_CRYSTAL_READY = 2;
  localparam int IRQ_MAIN_PLL_READY = 3;
  localparam int IRQ_SECOND_PLL_READY = 4;
  localparam int IRQ_THIRD_PLL_READY = 5;
  localparam int IRQ_W = 6;

  localparam logic [4:0] ADJ_RESET = 5'h10;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 6'h00;

  // System clock selection as reported by the clock switch.
  typedef enum logic [1:0] {
    SYS_RC = 2'b00,
    SYS_CRYSTAL = 2'b01,
    SYS_PLL = 2'b10
  } sys_src_e;

  // Enables sent out to the analogue sources.
  typedef struct packed {
    logic rc_osc_on;
    logic crystal_on;
    logic crystal_bypass;
    logic crystal_monitor_on;
    logic main_pll_on;
    logic second_pll_on;
    logic third_pll_on;
  } src_enable_s;

  // Ready indications returned from the analogue sources.
  typedef struct packed {
    logic rc_osc_ready;
    logic crystal_ready;
    logic main_pll_ready;
    logic second_pll_ready;
    logic third_pll_ready;
  } src_ready_s;

endpackage

// ==== logic/stable_gate.sv ====
// Stable-flag qualifier: a flag reads one in the cycle after its source is both enabled and reporting ready.
`timescale 1ns/1ps
module stable_gate (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic ready_i,
  output logic stable_o,
  output logic rise_o
);

  // Registered so the flag and its rising-edge event line up for software.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stable_o <= 1'b0;
    end else begin
      stable_o <= enable_i & ready_i;
    end
  end

  assign rise_o = enable_i & ready_i & ~stable_o;

endmodule

// ==== logic/rc_trim.sv ====
// Trim adder that forms the RC oscillator trim word from calibration and adjust.
`timescale 1ns/1ps
module rc_trim #(
  parameter int CAL_W = 8,
  parameter int ADJ_W = 5
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [CAL_W-1:0] cal_i,
  input wire logic [ADJ_W-1:0] adj_i,
  output logic [CAL_W-1:0] trim_o
);

  logic [CAL_W-1:0] trim_d;

  // The sum wraps at the calibration width; software keeps adjust in range.
  assign trim_d = cal_i + CAL_W'(adj_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trim_o <= '0;
    end else begin
      trim_o <= trim_d;
    end
  end

endmodule

// ==== logic/osc_ctl.sv ====
// Oscillator and PLL control register with clock monitor and interrupt status.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module osc_ctl (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic por_load_i,
  input wire logic [7:0] factory_cal_i,
  input wire logic low_power_entry_i,
  input wire logic low_power_exit_i,
  input wire osc_ctl_pkg::sys_src_e sys_src_i,
  input wire logic pll_from_crystal_i,
  input wire logic crystal_stuck_i,
  input wire logic ext_clk_i,
  input wire logic resonator_clk_i,
  input wire osc_ctl_pkg::src_ready_s ready_i,
  output osc_ctl_pkg::src_enable_s enable_o,
  output logic force_rc_o,
  output logic crystal_clk_o,
  output logic [7:0] rc_trim_o,
  output logic nmi_o,
  output logic irq_o
);
  import osc_ctl_pkg::*;

  logic rst_s1_q;
  logic rst_n_q;
  logic rc_on_q;
  logic crystal_on_q;
  logic bypass_q;
  logic monitor_on_q;
  logic main_pll_q;
  logic second_pll_q;
  logic third_pll_q;
  logic [4:0] adj_q;
  logic [7:0] cal_q;
  logic force_rc_q;
  logic [IRQ_W-1:0] status_q;
  logic [IRQ_W-1:0] mask_q;
  logic [31:0] rdata_q;
  logic fail_evt;
  logic wr_ctl;
  logic wr_sts;
  logic rc_eff;
  logic crystal_in_use;
  logic [4:0] stable;
  logic [4:0] rise;
  logic [4:0] src_en;
  logic [4:0] src_rdy;
  logic [IRQ_W-1:0] events;
  logic [31:0] ctl_word;

  // Reset release is synchronised; assertion stays asynchronous.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  assign wr_ctl = wr_i && (addr_i == ADDR_CONTROL);
  assign wr_sts = wr_i && (addr_i == ADDR_IRQ_STATUS);

  // A failure only counts while the monitor watches the crystal.
  assign fail_evt = monitor_on_q & crystal_on_q & crystal_stuck_i;
  assign crystal_in_use = (sys_src_i == SYS_CRYSTAL) || (sys_src_i == SYS_PLL && pll_from_crystal_i);

  // RC oscillator enable; hardware sets win over a software clear.
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rc_on_q <= 1'b1;
    end else if (low_power_exit_i || fail_evt) begin
      rc_on_q <= 1'b1;
    end else if (wr_ctl) begin
      // A refused clear keeps the bit; it never turns on an oscillator that was already off.
      rc_on_q <= wdata_i[BIT_RC_ON] | (rc_on_q & ((sys_src_i == SYS_RC) | force_rc_q));
    end
  end

  // Crystal enable and monitor enable.
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      crystal_on_q <= 1'b0;
      monitor_on_q <= 1'b0;
    end else begin
      if (low_power_entry_i) begin
        crystal_on_q <= 1'b0;
      end else if (fail_evt) begin
        crystal_on_q <= 1'b0;
      end else if (wr_ctl) begin
        crystal_on_q <= wdata_i[BIT_CRYSTAL_ON] | (crystal_on_q & crystal_in_use & ~force_rc_q);
      end
      if (wr_ctl) begin
        monitor_on_q <= wdata_i[BIT_MONITOR_ON];
      end
    end
  end

  // Bypass may only change while the crystal is off, so the mode never flips under a live clock.
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bypass_q <= 1'b0;
    end else if (wr_ctl && !crystal_on_q) begin
      bypass_q <= wdata_i[BIT_BYPASS];
    end
  end

  // PLL enables.
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      main_pll_q <= 1'b0;
      second_pll_q <= 1'b0;
      third_pll_q <= 1'b0;
    end else if (low_power_entry_i) begin
      main_pll_q <= 1'b0;
      second_pll_q <= 1'b0;
      third_pll_q <= 1'b0;
    end else if (fail_evt && pll_from_crystal_i) begin
      main_pll_q <= 1'b0;
    end else if (wr_ctl) begin
      main_pll_q <= wdata_i[BIT_MAIN_PLL_ON] | (main_pll_q & (sys_src_i == SYS_PLL) & ~force_rc_q);
      second_pll_q <= wdata_i[BIT_SECOND_PLL_ON];
      third_pll_q <= wdata_i[BIT_THIRD_PLL_ON];
    end
  end

  // Trim adjust is software-owned.
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      adj_q <= ADJ_RESET;
    end else if (wr_ctl) begin
      adj_q <= wdata_i[ADJ_LSB +: 5];
    end
  end

  // Calibration is captured on the power-on load strobe and is never written by software.
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cal_q <= 8'h00;
    end else if (por_load_i) begin
      cal_q <= factory_cal_i;
    end
  end

  // Forced RC selection sticks until reset or the failure flag is cleared.
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      force_rc_q <= 1'b0;
    end else if (fail_evt) begin
      force_rc_q <= 1'b1;
    end else if (wr_sts && wdata_i[IRQ_FAIL]) begin
      force_rc_q <= 1'b0;
    end
  end

  // Stable flags, one qualifier per source.
  assign src_en = {third_pll_q, second_pll_q, main_pll_q, crystal_on_q, rc_eff};
  assign src_rdy = {ready_i.third_pll_ready, ready_i.second_pll_ready, ready_i.main_pll_ready,
                    ready_i.crystal_ready, ready_i.rc_osc_ready};

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_stable
      stable_gate u_gate (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n_q),
        .enable_i(src_en[g]),
        .ready_i(src_rdy[g]),
        .stable_o(stable[g]),
        .rise_o(rise[g])
      );
    end
  endgenerate

  rc_trim #(.CAL_W(8), .ADJ_W(5)) u_trim (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_q),
    .cal_i(cal_q),
    .adj_i(adj_q),
    .trim_o(rc_trim_o)
  );

  // Interrupt status: set beats a write-one clear in the same cycle.
  assign events = {rise[4], rise[3], rise[2], rise[1], rise[0], fail_evt};
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status_q <= '0;
      mask_q <= IRQ_MASK_RESET;
    end else begin
      status_q <= events | (status_q & ~(wr_sts ? wdata_i[IRQ_W-1:0] : '0));
      if (wr_i && addr_i == ADDR_IRQ_MASK) begin
        mask_q <= wdata_i[IRQ_W-1:0];
      end
    end
  end

  // Control word as software sees it; reserved bits read zero.
  always_comb begin
    ctl_word = 32'h0000_0000;
    ctl_word[BIT_RC_ON] = rc_on_q;
    ctl_word[BIT_RC_STABLE] = stable[0];
    ctl_word[ADJ_LSB +: 5] = adj_q;
    ctl_word[CAL_LSB +: 8] = cal_q;
    ctl_word[BIT_CRYSTAL_ON] = crystal_on_q;
    ctl_word[BIT_CRYSTAL_STABLE] = stable[1];
    ctl_word[BIT_BYPASS] = bypass_q;
    ctl_word[BIT_MONITOR_ON] = monitor_on_q;
    ctl_word[BIT_MAIN_PLL_ON] = main_pll_q;
    ctl_word[BIT_MAIN_PLL_STABLE] = stable[2];
    ctl_word[BIT_SECOND_PLL_ON] = second_pll_q;
    ctl_word[BIT_SECOND_PLL_STABLE] = stable[3];
    ctl_word[BIT_THIRD_PLL_ON] = third_pll_q;
    ctl_word[BIT_THIRD_PLL_STABLE] = stable[4];
  end

  // Read data stand one cycle after the strobe and return to zero after.
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CONTROL: rdata_q <= ctl_word;
        ADDR_IRQ_STATUS: rdata_q <= {26'h0, status_q};
        ADDR_IRQ_MASK: rdata_q <= {26'h0, mask_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // The monitor keeps the RC running regardless of its enable bit.
  assign rc_eff = rc_on_q | monitor_on_q | force_rc_q;

  assign rdata_o = rdata_q;
  assign enable_o.rc_osc_on = rc_eff;
  assign enable_o.crystal_on = crystal_on_q & ~bypass_q;
  assign enable_o.crystal_bypass = bypass_q;
  assign enable_o.crystal_monitor_on = monitor_on_q;
  assign enable_o.main_pll_on = main_pll_q;
  assign enable_o.second_pll_on = second_pll_q;
  assign enable_o.third_pll_on = third_pll_q;
  assign force_rc_o = force_rc_q;
  // Clock path mux; this is a clock, not data, so it cannot be registered.
  assign crystal_clk_o = crystal_on_q & (bypass_q ? ext_clk_i : resonator_clk_i);
  assign nmi_o = status_q[IRQ_FAIL];
  assign irq_o = |(status_q & mask_q);

endmodule

// ==== verification/osc_src_model.sv ====
// Behavioural model of the oscillators and PLLs behind the control block.
`timescale 1ns/1ps
module osc_src_model #(
  parameter int DLY = 4
) (
  input wire logic sys_clk_i,
  input wire osc_ctl_pkg::src_enable_s enable_i,
  output osc_ctl_pkg::src_ready_s ready_o
);
  import osc_ctl_pkg::*;
  logic [4:0] on_w;
  int cnt_q [5];
  assign on_w = {enable_i.rc_osc_on, enable_i.crystal_on, enable_i.main_pll_on, enable_i.second_pll_on,
    enable_i.third_pll_on};
  // Each source settles a little later than the one before it, so the flags do not all move together.
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < 5; i++) begin
      cnt_q[i] <= on_w[i] ? ((cnt_q[i] < DLY + i) ? cnt_q[i] + 1 : cnt_q[i]) : 0;
    end
  end
  // Ready drops at once when a source is switched off, never holding a stale level.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      ready_o[i] = on_w[i] && (cnt_q[i] >= DLY + i);
    end
  end
endmodule

// ==== verification/osc_ctl_assertions.sv ====
// Concurrent checks on the ports of the oscillator control block.
`timescale 1ns/1ps
module osc_ctl_assertions (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic low_power_entry_i,
  input wire logic low_power_exit_i,
  input wire osc_ctl_pkg::sys_src_e sys_src_i,
  input wire logic crystal_stuck_i,
  input wire osc_ctl_pkg::src_enable_s enable_o,
  input wire logic force_rc_o,
  input wire logic nmi_o
);
  import osc_ctl_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Only a one written to the failure status bit may lift the forced switch.
  wire clr_fail = wr_i && addr_i == ADDR_IRQ_STATUS && wdata_i[IRQ_FAIL];
  a_low_power_off: assert property (
    low_power_entry_i |=> !(enable_o.main_pll_on || enable_o.second_pll_on || enable_o.third_pll_on ||
    enable_o.crystal_on)) else $error("enables survived low-power entry");
  a_main_pll_kept: assert property (
    enable_o.main_pll_on && sys_src_i == SYS_PLL && !low_power_entry_i && !crystal_stuck_i && !force_rc_o
    |=> enable_o.main_pll_on) else $error("main PLL dropped while in use");
  a_crystal_kept: assert property (
    enable_o.crystal_on && sys_src_i == SYS_CRYSTAL && !low_power_entry_i && !crystal_stuck_i && !force_rc_o
    |=> enable_o.crystal_on) else $error("crystal dropped while in use");
  a_monitor_rc: assert property (
    enable_o.crystal_monitor_on |-> enable_o.rc_osc_on) else $error("RC off while monitor on");
  a_fail_switch: assert property (
    enable_o.crystal_monitor_on && enable_o.crystal_on && crystal_stuck_i
    |=> force_rc_o && nmi_o && enable_o.rc_osc_on && !enable_o.crystal_on) else $error("failure not handled");
  a_force_hold: assert property (
    force_rc_o && !clr_fail |=> force_rc_o) else $error("forced RC lifted early");
  a_read_idle: assert property (
    !rd_i |=> rdata_o == 32'h0) else $error("read data outside read slot");
  a_wake_rc: assert property (
    low_power_exit_i |=> enable_o.rc_osc_on) else $error("RC not set on wake");
  a_stable_off: assert property (
    rd_i && addr_i == ADDR_CONTROL && !enable_o.third_pll_on && !$past(enable_o.third_pll_on)
    |=> !rdata_o[BIT_THIRD_PLL_STABLE]) else $error("stable flag with source off");
endmodule

// ==== verification/osc_ctl_tb.sv ====
// Self-checking bench for the oscillator control block.
`timescale 1ns/1ps
module osc_ctl_tb;
  import osc_ctl_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic por = 1'b0;
  logic lp_in = 1'b0;
  logic lp_out = 1'b0;
  logic stuck = 1'b0;
  logic ext_clk = 1'b0;
  logic pll_xtal = 1'b1;
  sys_src_e src = SYS_RC;
  logic [31:0] rdata;
  logic [7:0] trim;
  logic force_rc, xclk, nmi, irq;
  src_ready_s ready;
  src_enable_s en;
  int err_count = 0;
  int n_checks = 0;
  osc_ctl dut_u (.sys_clk_i(clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .por_load_i(por), .factory_cal_i(8'ha5), .low_power_entry_i(lp_in),
    .low_power_exit_i(lp_out), .sys_src_i(src), .pll_from_crystal_i(pll_xtal), .crystal_stuck_i(stuck),
    .ext_clk_i(ext_clk), .resonator_clk_i(1'b0), .ready_i(ready), .enable_o(en), .force_rc_o(force_rc),
    .crystal_clk_o(xclk), .rc_trim_o(trim), .nmi_o(nmi), .irq_o(irq));
  osc_src_model #(.DLY(4)) model_u (.sys_clk_i(clk), .enable_i(en), .ready_o(ready));
  // A 50 ns period clock.
  initial forever #25 clk = ~clk;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Read data are only valid in the cycle right after the strobe, so compare there.
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] msk, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata & msk, exp);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog sized well above the hundred or so cycles the sequence needs.
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    close_out();
  end
  // Main sequence; reserved fields are always written as zero.
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    step(12);
    rd_chk(ADDR_CONTROL, 32'hffff00ff, 32'h00000083);
    rd_chk(ADDR_IRQ_MASK, 32'hffffffff, {26'h0, IRQ_MASK_RESET});
    rd_chk(4'hc, 32'hffffffff, 32'h0);
    @(posedge clk);
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    wr_reg(ADDR_CONTROL, 32'h000000f8);
    rd_chk(ADDR_CONTROL, 32'h0000fff9, 32'h0000a5f9);
    chk({24'h0, trim}, 32'h000000c4);
    @(posedge clk);
    src <= SYS_PLL;
    wr_reg(ADDR_CONTROL, 32'h150100f9);
    step(12);
    rd_chk(ADDR_CONTROL, 32'h3f0f0000, 32'h3f030000);
    wr_reg(ADDR_CONTROL, 32'h150500f9);
    wr_reg(ADDR_CONTROL, 32'h000000f9);
    step(3);
    rd_chk(ADDR_CONTROL, 32'h3f0f0000, 32'h03030000);
    // A main PLL fed from elsewhere does not pin the crystal on.
    @(posedge clk);
    pll_xtal <= 1'b0;
    wr_reg(ADDR_CONTROL, 32'h010000f9);
    rd_chk(ADDR_CONTROL, 32'h01010000, 32'h01000000);
    @(posedge clk);
    pll_xtal <= 1'b1;
    wr_reg(ADDR_CONTROL, 32'h010900f9);
    @(posedge clk);
    stuck <= 1'b1;
    @(posedge clk);
    stuck <= 1'b0;
    src <= SYS_RC;
    step(6);
    chk({30'h0, force_rc, nmi}, 32'h3);
    rd_chk(ADDR_CONTROL, 32'h01050001, 32'h00000001);
    rd_chk(ADDR_IRQ_STATUS, 32'h0000003f, 32'h0000003f);
    chk({31'h0, irq}, 32'h0);
    wr_reg(ADDR_IRQ_MASK, 32'h00000001);
    step(1);
    chk({31'h0, irq}, 32'h1);
    wr_reg(ADDR_IRQ_STATUS, 32'h00000001);
    step(1);
    chk({29'h0, force_rc, nmi, irq}, 32'h0);
    @(posedge clk);
    src <= SYS_CRYSTAL;
    wr_reg(ADDR_CONTROL, 32'h000800f8);
    chk({31'h0, en.rc_osc_on}, 32'h1);
    chk({31'h0, en.crystal_on}, 32'h0);
    wr_reg(ADDR_CONTROL, 32'h000000f8);
    step(3);
    rd_chk(ADDR_CONTROL, 32'h00000003, 32'h0);
    wr_reg(ADDR_CONTROL, 32'h100100f8);
    @(posedge clk);
    lp_in <= 1'b1;
    @(posedge clk);
    lp_in <= 1'b0;
    lp_out <= 1'b1;
    @(posedge clk);
    lp_out <= 1'b0;
    rd_chk(ADDR_CONTROL, 32'h15010001, 32'h00000001);
    @(posedge clk);
    src <= SYS_RC;
    wr_reg(ADDR_CONTROL, 32'h000400f9);
    wr_reg(ADDR_CONTROL, 32'h000500f9);
    chk({30'h0, en.crystal_bypass, en.crystal_on}, 32'h2);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      ext_clk <= ~ext_clk;
      #1;
      chk({31'h0, xclk}, {31'h0, ext_clk});
    end
    close_out();
  end
endmodule
bind osc_ctl osc_ctl_assertions chk_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .low_power_entry_i(low_power_entry_i),
  .low_power_exit_i(low_power_exit_i), .sys_src_i(sys_src_i), .crystal_stuck_i(crystal_stuck_i),
  .enable_o(enable_o), .force_rc_o(force_rc_o), .nmi_o(nmi_o));
